/* File: core/core_supply_supervisor_lpm.sv */
// low-side core supply supervisor, settling delays and deep-sleep wake
module core_supply_supervisor_lpm
  import supply_supervisor_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire low_side_cfg_t low_side_supervisor_control,
  input wire logic low_side_ctl_write,
  input wire logic high_side_ctl_write,
  input wire logic high_side_settled,
  input wire logic core_level_raise,
  input wire logic deep_sleep_enter,
  input wire logic wake_irq,
  input wire logic power_up_clear,
  output logic low_side_delay_pending_flag,
  output logic high_side_delay_pending_flag,
  output sup_state_t supervisor_active_state,
  output sup_state_t supervisor_sleep_state,
  output sup_state_t monitor_active_state,
  output sup_state_t monitor_sleep_state,
  output logic wake_hazard,
  output logic in_deep_sleep,
  output logic wake_failed,
  output logic supply_reset_req
);

  // ----------------------------------------------------------------
  // state mapping
  // ----------------------------------------------------------------
  low_side_cfg_t cfg;
  sup_state_t sup_am;
  sup_state_t sup_lpm;
  sup_state_t mon_am;
  sup_state_t mon_lpm;
  logic hazard;

  assign cfg = low_side_supervisor_control;

  always_comb
  begin
    sup_am = sup_off;
    sup_lpm = sup_off;
    if (cfg.low_supervisor_enable_bit)
    begin
      sup_am = cfg.low_supervisor_fast_perf_sel ? sup_full_perf
                                                : sup_normal;
      if (cfg.low_supervisor_keep_in_sleep)
      begin
        if (!cfg.low_side_auto_control_sel)
          sup_lpm = sup_am;
        else if (cfg.low_supervisor_fast_perf_sel)
          sup_lpm = sup_normal;
        else
          sup_lpm = sup_off;
      end
    end
    // monitor has no off-in-sleep option: only automatic control drops it
    mon_am = sup_off;
    mon_lpm = sup_off;
    if (cfg.low_monitor_enable_bit)
    begin
      mon_am = cfg.low_monitor_fast_perf_sel ? sup_full_perf : sup_normal;
      if (!cfg.low_side_auto_control_sel)
        mon_lpm = mon_am;
      else if (cfg.low_monitor_fast_perf_sel)
        mon_lpm = sup_normal;
      else
        mon_lpm = sup_off;
    end
    hazard = !cfg.low_supervisor_enable_bit ||
             cfg.low_supervisor_fast_perf_sel ||
             !cfg.low_monitor_enable_bit ||
             cfg.low_monitor_fast_perf_sel;
  end

  // ----------------------------------------------------------------
  // settling delay after reconfiguration
  // ----------------------------------------------------------------
  logic settle_start;
  logic settle_busy;
  logic settle_done;
  logic [count_w-1:0] settle_load;

  assign settle_start = low_side_ctl_write;
  // the fast delay is far shorter than the core ramp, hence the reset
  assign settle_load = cfg.low_supervisor_fast_perf_sel
                       ? count_w'(fast_settle_cycles)
                       : count_w'(slow_settle_cycles);

  settle_timer settle_u
  (
    .clock(clock),
    .rst(rst),
    .start(settle_start),
    .load_value(settle_load),
    .busy(settle_busy),
    .done(settle_done)
  );

  // ----------------------------------------------------------------
  // core level ramp and deep-sleep sequencing
  // ----------------------------------------------------------------
  power_state_t pstate_r;
  power_state_t pstate_nxt;
  logic ramp_fast_r;
  logic ramp_fast_nxt;
  logic reset_req_r;
  logic reset_req_nxt;
  logic hazard_entry_r;
  logic hazard_entry_nxt;
  logic [count_w-1:0] win_r;
  logic [count_w-1:0] win_nxt;
  logic [count_w-1:0] wake_r;
  logic [count_w-1:0] wake_nxt;
  logic high_pending_r;
  logic high_pending_nxt;

  always_comb
  begin
    pstate_nxt = pstate_r;
    ramp_fast_nxt = ramp_fast_r;
    reset_req_nxt = 1'b0;
    hazard_entry_nxt = hazard_entry_r;
    win_nxt = win_r;
    wake_nxt = wake_r;
    high_pending_nxt = high_pending_r;
    if (high_side_ctl_write)
      high_pending_nxt = 1'b1;
    else if (high_side_settled)
      high_pending_nxt = 1'b0;
    // software is expected to clear the fast select first; the design
    // only models the consequence when it does not
    if (core_level_raise)
      ramp_fast_nxt = cfg.low_supervisor_fast_perf_sel;
    if (settle_done && ramp_fast_r)
    begin
      reset_req_nxt = 1'b1;
      ramp_fast_nxt = 1'b0;
    end
    if (win_r != count_zero)
      win_nxt = win_r - 16'h0001;
    unique case (pstate_r)
      pm_active:
      begin
        if (deep_sleep_enter)
        begin
          pstate_nxt = pm_deep_sleep;
          // skipping the settle wait is just as dangerous
          hazard_entry_nxt = hazard || settle_busy ||
                             high_pending_r;
          win_nxt = count_w'(hazard_window_cycles);
        end
      end
      pm_deep_sleep:
      begin
        if (wake_irq)
        begin
          if (hazard_entry_r && (win_r != count_zero))
            pstate_nxt = pm_stuck;
          else
          begin
            pstate_nxt = pm_waking;
            wake_nxt = cfg.low_supervisor_fast_perf_sel
                       ? count_w'(fast_wake_cycles)
                       : count_w'(slow_wake_cycles);
          end
        end
      end
      pm_waking:
      begin
        if (wake_r == count_zero)
          pstate_nxt = pm_active;
        else
          wake_nxt = wake_r - 16'h0001;
      end
      pm_stuck:
      begin
        pstate_nxt = pm_stuck;
      end
    endcase
    if (power_up_clear)
    begin
      pstate_nxt = pm_active;
      hazard_entry_nxt = 1'b0;
      win_nxt = count_zero;
      wake_nxt = count_zero;
    end
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      pstate_r <= pm_active;
      ramp_fast_r <= 1'b0;
      reset_req_r <= 1'b0;
      hazard_entry_r <= 1'b0;
      win_r <= count_zero;
      wake_r <= count_zero;
      high_pending_r <= 1'b0;
    end
    else
    begin
      pstate_r <= pstate_nxt;
      ramp_fast_r <= ramp_fast_nxt;
      reset_req_r <= reset_req_nxt;
      hazard_entry_r <= hazard_entry_nxt;
      win_r <= win_nxt;
      wake_r <= wake_nxt;
      high_pending_r <= high_pending_nxt;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign low_side_delay_pending_flag = settle_busy;
  assign high_side_delay_pending_flag = high_pending_r;
  assign supervisor_active_state = sup_am;
  assign supervisor_sleep_state = sup_lpm;
  assign monitor_active_state = mon_am;
  assign monitor_sleep_state = mon_lpm;
  assign wake_hazard = hazard;
  assign in_deep_sleep = (pstate_r == pm_deep_sleep) ||
                         (pstate_r == pm_stuck);
  assign wake_failed = (pstate_r == pm_stuck);
  assign supply_reset_req = reset_req_r;

endmodule // core_supply_supervisor_lpm

/* File: core/settle_timer.sv */
// down-counter that times comparator settling delays; wake-up delays are counted in the supervisor itself
module settle_timer
  import supply_supervisor_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic start,
  input wire logic [count_w-1:0] load_value,
  output logic busy,
  output logic done
);

  logic [count_w-1:0] count_r;
  logic [count_w-1:0] count_nxt;
  logic done_r;
  logic done_nxt;

  always_comb
  begin
    count_nxt = count_r;
    done_nxt = 1'b0;
    if (start)
    begin
      count_nxt = load_value;
    end
    else if (count_r != count_zero)
    begin
      count_nxt = count_r - 16'h0001;
      done_nxt = (count_r == 16'h0001);
    end
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      count_r <= count_zero;
      done_r <= 1'b0;
    end
    else
    begin
      count_r <= count_nxt;
      done_r <= done_nxt;
    end
  end

  assign busy = (count_r != count_zero);
  assign done = done_r;

endmodule // settle_timer

/* File: core/supply_supervisor_pkg.sv */
// shared constants and types for the low-side core supply supervisor
package supply_supervisor_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int clock_mhz = 50;
  localparam int fast_settle_ns = 2000;
  localparam int slow_settle_us = 150;
  localparam int slow_wake_us = 150;
  localparam int fast_wake_ns = 2000;
  localparam int fast_settle_cycles = (fast_settle_ns * clock_mhz) / 1000;
  localparam int slow_settle_cycles = slow_settle_us * clock_mhz;
  localparam int slow_wake_cycles = slow_wake_us * clock_mhz;
  localparam int fast_wake_cycles = (fast_wake_ns * clock_mhz) / 1000;
  // window after deep-sleep entry in which a wake-up can be lost
  localparam int hazard_window_cycles = 50;
  localparam int count_w = 16;
  localparam logic [count_w-1:0] count_zero = 16'h0000;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0]
  {
    sup_off = 2'b00,
    sup_normal = 2'b01,
    sup_full_perf = 2'b10
  } sup_state_t;

  typedef enum logic [1:0]
  {
    pm_active = 2'b00,
    pm_deep_sleep = 2'b01,
    pm_waking = 2'b10,
    pm_stuck = 2'b11
  } power_state_t;

  typedef struct packed
  {
    logic low_supervisor_enable_bit;
    logic low_supervisor_keep_in_sleep;
    logic low_supervisor_fast_perf_sel;
    logic low_monitor_enable_bit;
    logic low_monitor_fast_perf_sel;
    logic low_side_auto_control_sel;
  } low_side_cfg_t;

endpackage

/* File: sim/supervisor_checker_properties.sv */
// port-level checker for the core supply supervisor
module supervisor_checker
  import supply_supervisor_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire low_side_cfg_t low_side_supervisor_control,
  input wire logic low_side_ctl_write,
  input wire logic deep_sleep_enter,
  input wire logic power_up_clear,
  input wire logic low_side_delay_pending_flag,
  input wire sup_state_t supervisor_active_state,
  input wire sup_state_t supervisor_sleep_state,
  input wire sup_state_t monitor_sleep_state,
  input wire logic wake_hazard,
  input wire logic in_deep_sleep,
  input wire logic wake_failed,
  input wire logic supply_reset_req
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----
  // expected maps
  // ----
  wire low_side_cfg_t c = low_side_supervisor_control;
  wire logic en = c.low_supervisor_enable_bit;
  wire logic fp = c.low_supervisor_fast_perf_sel;
  wire logic men = c.low_monitor_enable_bit;
  wire logic mfp = c.low_monitor_fast_perf_sel;
  wire logic aut = c.low_side_auto_control_sel;
  wire logic pend = low_side_delay_pending_flag;
  wire sup_state_t sa = !en ? sup_off : fp ? sup_full_perf : sup_normal;
  wire sup_state_t ss = !(en && c.low_supervisor_keep_in_sleep) ? sup_off :
    !aut ? sa : fp ? sup_normal : sup_off;
  wire sup_state_t ms = !men ? sup_off : !aut ?
    (mfp ? sup_full_perf : sup_normal) : mfp ? sup_normal : sup_off;
  // ----
  // assertions
  // ----
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  a_active_map: assert property (supervisor_active_state == sa)
    else $error("active map");
  a_sleep_map: assert property (supervisor_sleep_state == ss)
    else $error("sleep map");
  a_monitor_map: assert property (monitor_sleep_state == ms)
    else $error("monitor map");
  a_hazard_map: assert property
    (wake_hazard == (!en || fp || !men || mfp))
    else $error("hazard map");
  // a rewrite inside the window restarts the count and is not covered here
  a_fast_settle: assert property
    (low_side_ctl_write && en && fp |=> pend [*8] ##92 pend ##1 !pend)
    else $error("fast settle");
  a_enter_sleep: assert property
    (deep_sleep_enter && !in_deep_sleep && !power_up_clear |=> in_deep_sleep)
    else $error("no entry");
  a_stuck_holds: assert property
    (wake_failed && !power_up_clear |=> wake_failed && in_deep_sleep)
    else $error("stuck lost");
  a_clear_recovers: assert property
    (power_up_clear |=> !wake_failed && !in_deep_sleep)
    else $error("no recovery");
  a_reset_pulse: assert property
    (supply_reset_req |=> !supply_reset_req)
    else $error("reset pulse");
  c_failed: cover property (wake_failed);
  c_reset: cover property (supply_reset_req);
  c_clear: cover property (power_up_clear && wake_failed);
endmodule // supervisor_checker

bind core_supply_supervisor_lpm supervisor_checker chk (.*);

/* File: sim/tb_top.sv */
// self-checking bench for the core supply supervisor
module tb_top
  import supply_supervisor_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock = 1'b0;
  logic rst = 1'b1;
  low_side_cfg_t low_side_supervisor_control = 6'h00;
  logic low_side_ctl_write = 1'b0;
  logic high_side_ctl_write = 1'b0;
  logic high_side_settled = 1'b0;
  logic core_level_raise = 1'b0;
  logic deep_sleep_enter = 1'b0;
  logic wake_irq = 1'b0;
  logic power_up_clear = 1'b0;
  logic low_side_delay_pending_flag, high_side_delay_pending_flag;
  logic wake_hazard, in_deep_sleep, wake_failed, supply_reset_req;
  sup_state_t supervisor_active_state, supervisor_sleep_state;
  sup_state_t monitor_active_state, monitor_sleep_state;
  int n_mismatch = 0;
  int num_checks = 0;
  int cycles = 0;
  int n;
  // rows: cfg, active, sleep, monitor active, monitor sleep, hazard
  logic [14:0] rows [9] = '{15'h0001, 15'h488a, 15'h590b, 15'h68aa,
    15'h7d55, 15'h7f33, 15'h6a88, 15'h4a88, 15'h60a1};
  wire logic [14:0] seen = {low_side_supervisor_control,
    supervisor_active_state, supervisor_sleep_state,
    monitor_active_state, monitor_sleep_state, wake_hazard};
  wire logic [14:0] flags = {10'h000, low_side_delay_pending_flag,
    high_side_delay_pending_flag, in_deep_sleep, wake_failed,
    supply_reset_req};
  core_supply_supervisor_lpm dut (.*);
  always #10 clock = ~clock;
  // ----
  // tasks
  // ----
  task automatic check(input logic [14:0] got, input logic [14:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic tick(input int k);
    repeat (k) @(negedge clock);
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    tick(1);
    s = 1'b0;
  endtask
  // measures how long the pending flag stands after a write
  task automatic settle(input int load);
    pulse(low_side_ctl_write);
    n = 1;
    while (low_side_delay_pending_flag === 1'b1 && n < 9000)
    begin
      tick(1);
      n++;
    end
    check(n >= load - 1 && n <= load + 1, 15'h1);
  endtask
  task automatic sleep(input int gap, input logic fail);
    pulse(deep_sleep_enter);
    check(in_deep_sleep, 15'h1);
    tick(gap);
    pulse(wake_irq);
    tick(3);
    check({wake_failed, in_deep_sleep}, {fail, fail});
  endtask
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 60000)
    begin
      n_mismatch++;
      conclude();
    end
  end
  // ----
  // sequence
  // ----
  initial
  begin
    tick(12);
    rst = 1'b0;
    tick(1);
    check(flags, 15'h0);
    foreach (rows[i])
    begin
      low_side_supervisor_control = rows[i][14:9];
      tick(1);
      check(seen, rows[i]);
    end
    low_side_supervisor_control = 6'h34;
    settle(7500);
    sleep(5, 1'b0);
    // slow wake takes 7500 cycles; a new entry is ignored until it ends
    tick(7600);
    pulse(low_side_ctl_write);
    sleep(5, 1'b1);
    pulse(power_up_clear);
    check({wake_failed, in_deep_sleep}, 15'h0);
    tick(7600);
    low_side_supervisor_control = 6'h3e;
    settle(100);
    sleep(5, 1'b1);
    rst = 1'b1;
    tick(1);
    rst = 1'b0;
    tick(1);
    check(flags, 15'h0);
    sleep(60, 1'b0);
    // fast settle with a raise: the reset follows the short count
    pulse(low_side_ctl_write);
    pulse(core_level_raise);
    n = 0;
    while (supply_reset_req !== 1'b1 && n < 300)
    begin
      tick(1);
      n++;
    end
    check(supply_reset_req, 15'h1);
    tick(1);
    check(supply_reset_req, 15'h0);
    low_side_supervisor_control = 6'h34;
    pulse(low_side_ctl_write);
    pulse(core_level_raise);
    n = 0;
    repeat (7600)
    begin
      tick(1);
      n += int'(supply_reset_req === 1'b1);
    end
    check(n == 0, 15'h1);
    // high-side write alone makes the next entry hazardous
    pulse(high_side_ctl_write);
    check(high_side_delay_pending_flag, 15'h1);
    sleep(5, 1'b1);
    pulse(power_up_clear);
    pulse(high_side_settled);
    check({high_side_delay_pending_flag, in_deep_sleep}, 15'h0);
    conclude();
  end
endmodule // tb_top
